// ---- core/psm_midplane.sv ----
// midplane supply gating, two port expanders and a small record memory
//
// The address map and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
`include "psm_defs.svh"
module psm_midplane import psm_pkg::*; (
  // clock and reset
  input  wire logic       pclk,
  input  wire logic       presetn,
  // supply side
  input  wire logic [2:0] ac_input_low_flag,
  input  wire logic [2:0] supply_x_healthy,
  input  wire logic [2:0] supply_installed_n,
  input  wire logic [2:0] fan_wear_warning,
  input  wire logic       bypass_jumper,
  input  wire logic       front_panel_power_on,
  output logic            supply_enable,
  output logic            margin_enable_n,
  output logic            margin_direction_pin,
  output logic [1:0]      margin_state,
  // record lines of the supplies, multiplexed onto the link
  output logic            supply_fru_clock,
  input  wire logic       supply_fru_data,
  // link
  psm_link_if.midplane    link
);
  typedef struct packed {
    psm_slv_state_t       st;
    logic                 scl_d;
    logic                 sda_d;
    logic [7:0]           sh;
    logic [3:0]           cnt;
    logic [1:0]           sel;
    logic                 rd;
    logic                 first;
    logic [3:0]           ptr;
    logic [7:0]           out1;
    logic                 sda_oe;
    logic                 fru_sel;
  } psm_mid_t;

  psm_mid_t q, d;
  logic [7:0] eep [`PSM_EEP_DEPTH];
  logic [7:0] port0, port1, rd_byte;
  logic [2:0] ac_valid_n;
  logic [1:0] good_cnt;
  logic       start_c, stop_c, rise, fall, eep_we;

  function automatic logic [1:0] psm_count3(input logic [2:0] v);
    psm_count3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
  endfunction

  // ----------------------------------------
  // supply gating and port images
  // ----------------------------------------
  assign ac_valid_n = ~ac_input_low_flag;
  assign good_cnt   = psm_count3(~ac_input_low_flag);
  // a single good supply cannot carry the load, so it is held off unless bypass_jumper is set
  assign supply_enable = front_panel_power_on &&
                         (bypass_jumper || good_cnt >= `PSM_AC_MIN_GOOD);
  assign port0 = {2'b11, supply_installed_n[2], supply_x_healthy[2],
                  supply_installed_n[1], supply_x_healthy[1],
                  supply_installed_n[0], supply_x_healthy[0]};
  assign port1 = {q.out1[`PSM_BIT_MARGIN_DIR], q.out1[`PSM_BIT_MARGIN_EN], ac_valid_n,
                  fan_wear_warning[0], fan_wear_warning[1], fan_wear_warning[2]};
  assign margin_enable_n      = q.out1[`PSM_BIT_MARGIN_EN];
  assign margin_direction_pin = q.out1[`PSM_BIT_MARGIN_DIR];
  // 01 raise 5 percent, 10 lower 5 percent, 00 nominal
  assign margin_state = margin_enable_n ? 2'b00 :
                        (margin_direction_pin ? 2'b10 : 2'b01);
  // record clock follows the link clock while a supply record is selected, and idles high otherwise
  assign supply_fru_clock = q.fru_sel ? link.scl_o : 1'b1;

  always_comb begin
    case (q.sel)
      2'd0:    rd_byte = port0;
      2'd1:    rd_byte = port1;
      2'd2:    rd_byte = eep[q.ptr];
      default: rd_byte = 8'hff;
    endcase
  end

  // ----------------------------------------
  // i2c slave, sampled on pclk
  // ----------------------------------------
  assign start_c = q.scl_d && link.scl_o && q.sda_d && !link.sda;
  assign stop_c  = q.scl_d && link.scl_o && !q.sda_d && link.sda;
  assign rise    = !q.scl_d && link.scl_o;
  assign fall    = q.scl_d && !link.scl_o;
  assign eep_we  = q.st == PSM_DACK && fall && q.sel == 2'd2 && !q.rd && !q.first;

  always_comb begin
    d       = q;
    d.scl_d = link.scl_o;
    d.sda_d = link.sda;
    if (start_c) begin
      d.st = PSM_ADDR;
      d.cnt = 4'd0;
      d.sda_oe = 1'b0;
      d.fru_sel = 1'b0;
    end else if (stop_c) begin
      d.st = PSM_IDLE;
      d.sda_oe = 1'b0;
      d.fru_sel = 1'b0;
    end else begin
      case (q.st)
        PSM_IDLE: d.sda_oe = 1'b0;
        PSM_ADDR: begin
          if (rise) begin
            d.sh  = {q.sh[6:0], link.sda};
            d.cnt = q.cnt + 4'd1;
          end
          if (fall && q.cnt == 4'd8) begin
            d.rd    = q.sh[0];
            d.first = 1'b1;
            d.cnt   = 4'd0;
            d.st    = PSM_ACK;
            d.sda_oe = 1'b1;
            case (q.sh[7:1])
              `PSM_EXP0_ADDR: d.sel = 2'd0;
              `PSM_EXP1_ADDR: d.sel = 2'd1;
              `PSM_EEP_ADDR:  d.sel = 2'd2;
              default: begin
                d.st = PSM_IDLE;
                d.sda_oe = 1'b0;
                d.fru_sel = 1'b1;
              end
            endcase
          end
        end
        PSM_ACK, PSM_DACK: begin
          if (fall) begin
            d.st  = PSM_DATA;
            d.cnt = 4'd0;
            if (q.rd && !(q.st == PSM_DACK && link.sda)) begin
              d.sh = rd_byte;
              d.sda_oe = !rd_byte[7];
              if (q.sel == 2'd2 && q.st == PSM_DACK) d.ptr = q.ptr + 4'd1;
            end else begin
              d.sda_oe = 1'b0;
              if (q.rd) d.st = PSM_IDLE;
            end
            if (eep_we && q.sel == 2'd2) d.ptr = q.ptr + 4'd1;
            if (q.st == PSM_DACK) d.first = 1'b0;
          end
        end
        PSM_DATA: begin
          if (rise) begin
            d.cnt = q.cnt + 4'd1;
            if (!q.rd) d.sh = {q.sh[6:0], link.sda};
          end
          if (fall && q.rd && q.cnt != 4'd8) begin
            d.sh = {q.sh[6:0], 1'b1};
            d.sda_oe = !q.sh[6];
          end
          if (fall && q.cnt == 4'd8) begin
            d.st = PSM_DACK;
            d.sda_oe = !q.rd;
            if (!q.rd && q.sel == 2'd1) d.out1 = q.sh;
            if (!q.rd && q.sel == 2'd2 && q.first) d.ptr = q.sh[3:0];
          end
        end
        default: d.st = PSM_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: PSM_IDLE, scl_d: 1'b1, sda_d: 1'b1, sh: 8'h00, cnt: 4'h0,
             sel: 2'h0, rd: 1'b0, first: 1'b0, ptr: 4'h0, out1: `PSM_OUT_RESET,
             sda_oe: 1'b0, fru_sel: 1'b0};
    end else begin
      q <= d;
    end
  end

  // record memory keeps no reset: it is storage, not control
  always_ff @(posedge pclk) begin
    if (q.st == PSM_DATA && fall && q.cnt == 4'd8 && !q.rd && q.sel == 2'd2 && !q.first) begin
      eep[q.ptr] <= q.sh;
    end
  end

  assign link.sda_s_o  = 1'b0;
  // a selected supply record drives the link through the data line
  assign link.sda_s_oe = q.sda_oe || (q.fru_sel && !supply_fru_data);
endmodule

// ---- core/psm_defs.svh ----
// constants for the supply monitor expanders and its i2c link
`ifndef PSM_DEFS_SVH
`define PSM_DEFS_SVH
`define PSM_EXP0_ADDR      7'h20
`define PSM_EXP1_ADDR      7'h21
`define PSM_EEP_ADDR       7'h50
`define PSM_AC_MIN_GOOD    2'd2
`define PSM_BIT_MARGIN_EN  6
`define PSM_BIT_MARGIN_DIR 7
`define PSM_OUT_RESET      8'hff
`define PSM_EEP_DEPTH      16
`define PSM_REG_CTRL       12'h000
`define PSM_REG_STAT       12'h004
`define PSM_REG_EXP0       12'h008
`define PSM_REG_EXP1       12'h00c
`define PSM_REG_IRQ_ST     12'h010
`define PSM_REG_IRQ_MASK   12'h014
`define PSM_REG_EEP        12'h018
`define PSM_HALF_PERIOD    8'd124
`endif

// ---- core/psm_pkg.sv ----
// types shared by both ends of the supply monitor link
package psm_pkg;
  typedef enum logic [4:0] {
    PSM_IDLE  = 5'b00001,
    PSM_ADDR  = 5'b00010,
    PSM_ACK   = 5'b00100,
    PSM_DATA  = 5'b01000,
    PSM_DACK  = 5'b10000
  } psm_slv_state_t;
  typedef enum logic [5:0] {
    PSM_M_IDLE  = 6'b000001,
    PSM_M_START = 6'b000010,
    PSM_M_BITS  = 6'b000100,
    PSM_M_ACK   = 6'b001000,
    PSM_M_STOP  = 6'b010000,
    PSM_M_DONE  = 6'b100000
  } psm_mst_state_t;
endpackage

// ---- core/psm_link_if.sv ----
// i2c wires between the midplane expanders and the front panel controller
`timescale 1ns/1ps
interface psm_link_if;
  logic scl_o;
  logic sda_m_o;
  logic sda_m_oe;
  logic sda_s_o;
  logic sda_s_oe;
  logic sda;
  // open drain: low wins, pulled up otherwise
  assign sda = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));
  modport midplane (input scl_o, input sda, output sda_s_o, output sda_s_oe);
  modport controller (output scl_o, input sda, output sda_m_o, output sda_m_oe);
endinterface

// ---- core/psm_controller.sv ----
// front panel controller: apb registers driving an i2c master
`timescale 1ns/1ps
`include "psm_defs.svh"
module psm_controller import psm_pkg::*; (
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  // interrupt
  output logic             irq,
  // link
  psm_link_if.controller   link
);
  typedef struct packed {
    psm_mst_state_t st;
    logic [7:0]     div;
    logic [1:0]     ph;
    logic [3:0]     bitn;
    logic [7:0]     sh;
    logic [7:0]     wdat;
    logic [6:0]     addr;
    logic           rdir;
    logic           second;
    logic           nack;
    logic [7:0]     exp0;
    logic [7:0]     exp1;
    logic [1:0]     irq_st;
    logic [1:0]     irq_mask;
    logic [31:0]    rdata;
    logic           scl;
    logic           sda_oe;
  } psm_ctl_t;

  psm_ctl_t q, d;
  logic wr, rd, tick;
  assign wr   = psel && penable && pwrite;
  // read data is fetched in the setup cycle so that it stands at the access edge
  assign rd   = psel && !penable && !pwrite;
  assign tick = q.div == `PSM_HALF_PERIOD;
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign prdata  = q.rdata;
  assign irq     = |(q.irq_st & q.irq_mask);
  assign link.scl_o    = q.scl;
  assign link.sda_m_o  = 1'b0;
  assign link.sda_m_oe = q.sda_oe;

  always_comb begin
    d     = q;
    d.div = tick ? 8'h00 : q.div + 8'h01;
    // ctrl write: [6:0] address, [7] read, [15:8] data; starts a transfer only when idle
    if (wr && paddr == `PSM_REG_CTRL && q.st == PSM_M_IDLE) begin
      d.addr = pwdata[6:0];
      d.rdir = pwdata[7];
      d.wdat = pwdata[15:8];
      d.st   = PSM_M_START;
      d.ph   = 2'd0;
    end
    if (wr && paddr == `PSM_REG_IRQ_MASK) d.irq_mask = pwdata[1:0];
    if (wr && paddr == `PSM_REG_IRQ_ST) d.irq_st = q.irq_st & ~pwdata[1:0];
    if (rd) begin
      case (paddr)
        `PSM_REG_STAT:     d.rdata = {30'h0, q.nack, q.st != PSM_M_IDLE};
        `PSM_REG_EXP0:     d.rdata = {24'h0, q.exp0};
        `PSM_REG_EXP1:     d.rdata = {24'h0, q.exp1};
        `PSM_REG_IRQ_ST:   d.rdata = {30'h0, q.irq_st};
        `PSM_REG_IRQ_MASK: d.rdata = {30'h0, q.irq_mask};
        default:           d.rdata = 32'h0;
      endcase
    end
    if (tick) begin
      case (q.st)
        PSM_M_IDLE: begin
          d.scl = 1'b1;
          d.sda_oe = 1'b0;
        end
        PSM_M_START: begin
          d.sda_oe = 1'b1;
          d.sh     = {q.addr, q.rdir};
          d.second = 1'b0;
          d.bitn   = 4'd0;
          d.nack   = 1'b0;
          d.st     = PSM_M_BITS;
          d.ph     = 2'd0;
        end
        PSM_M_BITS: begin
          d.ph = q.ph + 2'd1;
          case (q.ph)
            2'd0: begin
              d.scl = 1'b0;
            end
            2'd1: d.sda_oe = (q.rdir && q.second) ? 1'b0 : !q.sh[7];
            2'd2: d.scl = 1'b1;
            default: begin
              d.sh   = {q.sh[6:0], link.sda};
              d.bitn = q.bitn + 4'd1;
              if (q.bitn == 4'd7) d.st = PSM_M_ACK;
            end
          endcase
        end
        PSM_M_ACK: begin
          d.ph = q.ph + 2'd1;
          case (q.ph)
            2'd0: d.scl = 1'b0;
            2'd1: d.sda_oe = q.rdir && q.second ? 1'b0 : 1'b0;
            2'd2: d.scl = 1'b1;
            default: begin
              d.bitn = 4'd0;
              if (!q.second && link.sda) begin
                d.nack = 1'b1;
                d.st   = PSM_M_STOP;
              end else if (!q.second) begin
                d.second = 1'b1;
                d.sh     = q.wdat;
                d.st     = PSM_M_BITS;
              end else begin
                if (q.rdir && q.addr == `PSM_EXP0_ADDR) d.exp0 = q.sh;
                if (q.rdir && q.addr == `PSM_EXP1_ADDR) d.exp1 = q.sh;
                d.st = PSM_M_STOP;
              end
            end
          endcase
        end
        PSM_M_STOP: begin
          d.ph = q.ph + 2'd1;
          case (q.ph)
            2'd0: d.scl = 1'b0;
            2'd1: d.sda_oe = 1'b1;
            2'd2: d.scl = 1'b1;
            default: begin
              d.sda_oe = 1'b0;
              d.st     = PSM_M_DONE;
            end
          endcase
        end
        PSM_M_DONE: d.st = PSM_M_IDLE;
        default:    d.st = PSM_M_IDLE;
      endcase
    end
    // hardware set wins over a clear in the same cycle
    if (tick && q.st == PSM_M_DONE) d.irq_st[0] = 1'b1;
    if (tick && q.st == PSM_M_STOP && q.ph == 2'd3 && q.nack) d.irq_st[1] = 1'b1;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '{st: PSM_M_IDLE, div: 8'h00, ph: 2'h0, bitn: 4'h0, sh: 8'h00, wdat: 8'h00,
             addr: 7'h00, rdir: 1'b0, second: 1'b0, nack: 1'b0, exp0: 8'h00,
             exp1: 8'h00, irq_st: 2'h0, irq_mask: 2'h0, rdata: 32'h0, scl: 1'b1,
             sda_oe: 1'b0};
    end else begin
      q <= d;
    end
  end
endmodule

// ---- verif/psm_chk.sv ----
// checker for the supply gating, margin pins and link wires
`timescale 1ns/1ps
module psm_chk (
  // clock and reset
  input wire logic       pclk,
  input wire logic       presetn,
  // link wires
  input wire logic       scl_o,
  input wire logic       sda_s_oe,
  // midplane pins
  input wire logic [2:0] ac_input_low_flag,
  input wire logic       bypass_jumper,
  input wire logic       front_panel_power_on,
  input wire logic       supply_enable,
  input wire logic       margin_enable_n,
  input wire logic       margin_direction_pin,
  input wire logic [1:0] margin_state,
  input wire logic       supply_fru_clock
);
  // ------------------------------------------------------------
  // helper logic
  // ------------------------------------------------------------
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [1:0] good_cnt;
  // a low raw line means the supply sees good input
  assign good_cnt = {1'b0, !ac_input_low_flag[0]} + {1'b0, !ac_input_low_flag[1]}
                  + {1'b0, !ac_input_low_flag[2]};
  // ------------------------------------------------------------
  // assertions
  // ------------------------------------------------------------
  gate_low_a: assert property (
    (good_cnt < 2'd2) && !bypass_jumper |-> !supply_enable)
    else $error("enable not forced low");
  pair_pass_a: assert property (
    (good_cnt >= 2'd2) && front_panel_power_on |-> supply_enable)
    else $error("enable blocked with two good supplies");
  bypass_pass_a: assert property (
    bypass_jumper && front_panel_power_on |-> supply_enable)
    else $error("bypass did not pass the request");
  power_off_a: assert property (
    !front_panel_power_on |-> !supply_enable)
    else $error("enable high without request");
  margin_decode_a: assert property (
    margin_state == {!margin_enable_n && margin_direction_pin,
                     !margin_enable_n && !margin_direction_pin})
    else $error("margin state decode wrong");
  margin_reset_a: assert property (
    $rose(presetn) |-> margin_enable_n && margin_direction_pin && (margin_state == 2'b00))
    else $error("margin not nominal after reset");
  fru_clock_a: assert property (
    scl_o |-> supply_fru_clock)
    else $error("record clock low while link clock high");
  slave_edge_a: assert property (
    $changed(sda_s_oe) |-> !scl_o)
    else $error("midplane moved data while clock high");
  // ------------------------------------------------------------
  // cover
  // ------------------------------------------------------------
  cover property ($rose(supply_enable));
  cover property (margin_state == 2'b01);
  cover property ($rose(sda_s_oe));
  cover property ($fell(supply_fru_clock));
endmodule

// ---- verif/tb.sv ----
// testbench: apb orders through the controller to the midplane expanders
`timescale 1ns/1ps
`include "psm_defs.svh"
module tb;
  // ------------------------------------------------------------
  // signals
  // ------------------------------------------------------------
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [2:0]  ac_flag, healthy, inst_n, warn;
  logic        jumper, pwr_on, sup_en, mg_en_n, mg_dir, fru_clk;
  logic [1:0]  mg_state, mg_v, mask_v;
  int          n_errors, cmp_count;
  psm_link_if  link ();
  psm_controller psm_controller_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq), .link(link.controller));
  psm_midplane psm_midplane_i (.pclk(pclk), .presetn(presetn), .ac_input_low_flag(ac_flag),
    .supply_x_healthy(healthy), .supply_installed_n(inst_n), .fan_wear_warning(warn),
    .bypass_jumper(jumper), .front_panel_power_on(pwr_on), .supply_enable(sup_en),
    .margin_enable_n(mg_en_n), .margin_direction_pin(mg_dir), .margin_state(mg_state),
    .supply_fru_clock(fru_clk), .supply_fru_data(1'b1), .link(link.midplane));
  psm_chk psm_chk_i (.pclk(pclk), .presetn(presetn), .scl_o(link.scl_o),
    .sda_s_oe(link.sda_s_oe), .ac_input_low_flag(ac_flag), .bypass_jumper(jumper),
    .front_panel_power_on(pwr_on), .supply_enable(sup_en), .margin_enable_n(mg_en_n),
    .margin_direction_pin(mg_dir), .margin_state(mg_state), .supply_fru_clock(fru_clk));
  // ------------------------------------------------------------
  // tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic close_out();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task automatic timeout();
    n_errors++;
    $display("FAIL %0t wait ran out", $time);
    close_out();
  endtask
  // the request stands until pready is seen high; read data is taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    k = 0;
    do begin
      @(posedge pclk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    if (k >= 50) timeout();
    rd = prdata;
    chk(pslverr, 1'b0);
    psel <= 1'b0;
    penable <= 1'b0;
    // one idle edge keeps two calls from driving psel twice in one step
    @(posedge pclk);
  endtask
  // one link transfer, finished by the done flag, then flags cleared
  task automatic xfer(input logic [6:0] a, input logic r, input logic [7:0] d,
                      input logic [1:0] ex);
    int k;
    apb(1'b1, `PSM_REG_CTRL, {16'h0, d, r, a});
    // a second order while busy must be ignored
    apb(1'b1, `PSM_REG_CTRL, {16'h0, d, r, a ^ 7'h7f});
    k = 0;
    do begin
      apb(1'b0, `PSM_REG_IRQ_ST, 32'h0);
      k++;
    end while (rd[0] !== 1'b1 && k < 4000);
    if (k >= 4000) timeout();
    chk(rd, {30'h0, ex});
    chk(irq, |(ex & mask_v));
    apb(1'b1, `PSM_REG_IRQ_ST, 32'h3);
    apb(1'b0, `PSM_REG_STAT, 32'h0);
    chk(rd, {30'h0, ex[1], 1'b0});
    chk(irq, 1'b0);
  endtask
  task automatic check_ports();
    xfer(`PSM_EXP0_ADDR, 1'b1, 8'h00, 2'b01);
    apb(1'b0, `PSM_REG_EXP0, 32'h0);
    chk(rd, {24'h0, 2'b11, inst_n[2], healthy[2], inst_n[1], healthy[1], inst_n[0],
             healthy[0]});
    xfer(`PSM_EXP1_ADDR, 1'b1, 8'h00, 2'b01);
    apb(1'b0, `PSM_REG_EXP1, 32'h0);
    chk(rd, {24'h0, mg_v, ~ac_flag[2], ~ac_flag[1], ~ac_flag[0], warn[0], warn[1],
             warn[2]});
  endtask
  // ------------------------------------------------------------
  // clock and main sequence
  // ------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    logic [11:0] ra [5];
    ra = '{`PSM_REG_STAT, `PSM_REG_EXP0, `PSM_REG_EXP1, `PSM_REG_IRQ_MASK, 12'h100};
    {presetn, psel, penable, pwrite, jumper, pwr_on} = 6'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    {ac_flag, healthy, inst_n, warn} = {3'h0, 3'h7, 3'h0, 3'h0};
    mg_v = 2'b11;
    mask_v = 2'b00;
    n_errors = 0;
    cmp_count = 0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk({mg_dir, mg_en_n, mg_state}, 4'hc);
    for (int i = 0; i < 5; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, 32'h0);
    end
    // every raw ac pattern, with and without jumper and request
    for (int v = 0; v < 32; v++) begin
      ac_flag <= v[2:0];
      jumper <= v[3];
      pwr_on <= v[4];
      @(posedge pclk);
      @(posedge pclk);
      chk(sup_en, v[4] && (v[3] || $countones(~v[2:0]) >= 2));
    end
    for (int p = 0; p < 2; p++) begin
      if (p == 1) begin
        apb(1'b1, `PSM_REG_IRQ_MASK, 32'h1);
        mask_v = 2'b01;
      end
      healthy <= p ? 3'h5 : 3'h2;
      inst_n <= p ? 3'h3 : 3'h4;
      warn <= p ? 3'h1 : 3'h6;
      ac_flag <= p ? 3'h2 : 3'h5;
      @(posedge pclk);
      check_ports();
    end
    // down, up, then nominal; inputs bits written high
    for (int m = 0; m < 3; m++) begin
      mg_v = (m == 0) ? 2'b10 : ((m == 1) ? 2'b00 : 2'b01);
      xfer(`PSM_EXP1_ADDR, 1'b0, {mg_v, 6'h3f}, 2'b01);
      chk({mg_dir, mg_en_n, mg_state}, {mg_v, !mg_v[0] && mg_v[1],
          !mg_v[0] && !mg_v[1]});
    end
    // an unknown address reaches the supply record lines; nobody answers, so nack
    xfer(7'h33, 1'b0, 8'h00, 2'b11);
    check_ports();
    close_out();
  end
endmodule
